// ===== src/obc_cfg.svh
// Constants for the option byte configuration decoder
`ifndef OBC_CFG_SVH
`define OBC_CFG_SVH

// Startup configuration byte field positions
`define OBC_SU_CLK_HI    7
`define OBC_SU_CLK_LO    6
`define OBC_SU_ONE_BIT   5
`define OBC_SU_ZERO_BIT  4
`define OBC_SU_BOD_HI    3
`define OBC_SU_BOD_LO    2
`define OBC_SU_WDT_TYPE  1
`define OBC_SU_WDT_HALT  0

// Protection configuration byte field positions
`define OBC_PR_RSVD_HI   7
`define OBC_PR_RSVD_LO   4
`define OBC_PR_SEC_HI    3
`define OBC_PR_SEC_LO    2
`define OBC_PR_RDP       1
`define OBC_PR_WRP       0
`define OBC_PR_RSVD_ONES 4'hF

// Delivered byte values and the erased cell value
`define OBC_SU_RESET     8'h2F
`define OBC_PR_RESET     8'hF0
`define OBC_ERASED       8'hFF

// Sector zero size in bytes
`define OBC_SEC_HALF_K   12'h200
`define OBC_SEC_ONE_K    12'h400
`define OBC_SEC_TWO_K    12'h800

// Programming tool command codes
`define OBC_CMD_RD_OPT   3'h0
`define OBC_CMD_WR_OPT   3'h1
`define OBC_CMD_ER_OPT   3'h2
`define OBC_CMD_RD_MEM   3'h3
`define OBC_CMD_PR_MEM   3'h4
`define OBC_CMD_ER_MEM   3'h5

// Byte select on the tool port
`define OBC_SEL_PR       1'h0
`define OBC_SEL_SU       1'h1

// Program memory operation codes
`define OBC_MOP_READ     2'h0
`define OBC_MOP_PROG     2'h1
`define OBC_MOP_ERASE    2'h2

`endif

// ===== src/obc_pkg.sv
// Types shared by the option byte configuration decoder
package obc_pkg;

    typedef enum logic [1:0] {
        OBC_CLK_RC,
        OBC_CLK_WAKEUP,
        OBC_CLK_RSVD,
        OBC_CLK_EXT
    } obc_clk_src_e;

    typedef enum logic [2:0] {
        OBC_IDLE,
        OBC_NV_WAIT,
        OBC_MEM_WAIT,
        OBC_WIPE_WAIT,
        OBC_OPT_ERASE
    } obc_state_e;

endpackage

// ===== src/obc_cfg_if.sv
// Carrier for held option bytes and their decoded settings
`timescale 1ns/100ps
interface obc_cfg_if;
    import obc_pkg::*;
    logic [7:0]   startup_byte;
    logic [7:0]   protect_byte;
    obc_clk_src_e clk_src;
    logic [1:0]   bod_sel;
    logic         bod_enable;
    logic         wdt_hw_enable;
    logic         wdt_halt_reset;
    logic [11:0]  sector_bytes;
    logic         readout_protect;
    logic         program_write_protect;
    logic         fixed_bit_fault;

    modport holder (output startup_byte, protect_byte);
    modport decoder (
        input  startup_byte, protect_byte,
        output clk_src, bod_sel, bod_enable, wdt_hw_enable,
        wdt_halt_reset, sector_bytes, readout_protect,
        program_write_protect, fixed_bit_fault
    );
endinterface

// ===== src/obc_hold.sv
// Captures the option bytes once after reset and holds them
`timescale 1ns/100ps
`include "obc_cfg.svh"
module obc_hold
    import obc_pkg::*;
(
    input  wire logic clk,          // System clock
    input  wire logic rst_n,        // Asynchronous reset, active low
    input  wire logic clk_en,       // Clock enable
    input  wire logic [7:0] nv_su,  // Live startup byte from the cells
    input  wire logic [7:0] nv_pr,  // Live protection byte from the cells
    output logic      loaded,       // Bytes captured since reset
    obc_cfg_if.holder cfg           // Held bytes
);
    logic [7:0] su;
    logic [7:0] pr;
    logic       next_loaded;
    logic [7:0] next_su;
    logic [7:0] next_pr;

    // Capture on the first enabled edge after release, then freeze
    always_comb
    begin
        next_loaded = loaded;
        next_su     = su;
        next_pr     = pr;
        if (clk_en && !loaded)
        begin
            next_loaded = 1'b1;  // [R14]
            next_su     = nv_su;
            next_pr     = nv_pr;
        end
    end

    // Reset holds the delivered values until the capture
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            loaded <= 1'b0;
            su     <= `OBC_SU_RESET;
            pr     <= `OBC_PR_RESET;
        end
        else
        begin
            loaded <= next_loaded;
            su     <= next_su;
            pr     <= next_pr;
        end
    end

    assign cfg.startup_byte = su;
    assign cfg.protect_byte = pr;
endmodule

// ===== src/obc_decode.sv
// Turns the held option bytes into hardware settings
`timescale 1ns/100ps
`include "obc_cfg.svh"
module obc_decode
    import obc_pkg::*;
(
    obc_cfg_if.decoder cfg          // Held bytes in, settings out
);
    // Field decode; the reserved clock code is passed on and flagged
    always_comb
    begin
        cfg.clk_src = obc_clk_src_e'(cfg.startup_byte[`OBC_SU_CLK_HI:`OBC_SU_CLK_LO]);  // [R1]
        cfg.bod_sel    = cfg.startup_byte[`OBC_SU_BOD_HI:`OBC_SU_BOD_LO];  // [R4]
        cfg.bod_enable = (cfg.bod_sel != 2'h3);  // [R4]
        cfg.wdt_hw_enable  = !cfg.startup_byte[`OBC_SU_WDT_TYPE];  // [R5]
        cfg.wdt_halt_reset = cfg.startup_byte[`OBC_SU_WDT_HALT];  // [R6]
        // Low size bit wins regardless of the high one
        if (cfg.protect_byte[`OBC_PR_SEC_LO])  // [R8]
            cfg.sector_bytes = `OBC_SEC_TWO_K;
        else if (cfg.protect_byte[`OBC_PR_SEC_HI])
            cfg.sector_bytes = `OBC_SEC_ONE_K;
        else
            cfg.sector_bytes = `OBC_SEC_HALF_K;
        cfg.readout_protect       = cfg.protect_byte[`OBC_PR_RDP];  // [R9]
        cfg.program_write_protect = cfg.protect_byte[`OBC_PR_WRP];  // [R11]
        // Fixed bits written wrong by the tool are reported, not repaired
        cfg.fixed_bit_fault =
            !cfg.startup_byte[`OBC_SU_ONE_BIT]                                 // [R2]
            || cfg.startup_byte[`OBC_SU_ZERO_BIT]                              // [R3]
            || (cfg.protect_byte[`OBC_PR_RSVD_HI:`OBC_PR_RSVD_LO]
                != `OBC_PR_RSVD_ONES)                                          // [R7]
            || (cfg.clk_src == OBC_CLK_RSVD);
    end
endmodule

// ===== src/obc_top.sv
// Option byte configuration decoder with programming-mode access control
`timescale 1ns/100ps
`include "obc_cfg.svh"
// Function
// [R1] Clock field selects RC, wakeup RC or external
// [R2] Tool writes startup bit 5 as one
// [R3] Tool writes startup bit 4 as zero
// [R4] Brownout field sets threshold or disables detector
// [R5] Watchdog type bit: hardware on or software
// [R6] Halt-reset bit resets on halt with watchdog
// [R7] Tool writes protection bits 7:4 as ones
// [R8] Sector field sets sector zero size
// [R9] Readout protect blocks extraction and memory writes
// [R10] Option erase under readout protect wipes memory first
// [R11] Write protect refuses all memory and bit changes; the code still accepts startup byte writes
// [R12] Option bytes reachable only in programming mode
// [R13] Erased program memory holds FFh everywhere
// [R14] Bytes sampled at reset, settings held after
module obc_top
    import obc_pkg::*;
(
    input  wire logic        clk,                  // System clock, 50 MHz
    input  wire logic        rst_n,                // Asynchronous reset, active low
    input  wire logic        clk_en,               // Freezes all state while low
    input  wire logic        prog_mode,            // Device is in programming mode
    input  wire logic        tool_req,             // Tool request strobe
    input  wire logic [2:0]  tool_cmd,             // Tool command code
    input  wire logic        tool_sel,             // Option byte select
    input  wire logic [10:0] tool_addr,            // Program memory address
    input  wire logic [7:0]  tool_wdata,           // Tool write data
    output logic      [7:0]  tool_rdata,           // Tool read data
    output logic             tool_done,            // Request completed
    output logic             tool_refused,         // Request refused
    output logic             tool_busy,            // Operation in progress
    input  wire logic [7:0]  nv_startup_byte,      // Live startup byte cell
    input  wire logic [7:0]  nv_protect_byte,      // Live protection byte cell
    output logic             nv_write,             // Option cell write strobe
    output logic             nv_wsel,              // Option cell select
    output logic      [7:0]  nv_wdata,             // Option cell write data
    input  wire logic        nv_done,              // Option cell operation done
    output logic             mem_req,              // Program memory strobe
    output logic      [1:0]  mem_op,               // Program memory operation
    output logic      [10:0] mem_addr,             // Program memory address
    output logic      [7:0]  mem_wdata,            // Program memory write data
    input  wire logic [7:0]  mem_rdata,            // Program memory read data
    input  wire logic        mem_done,             // Program memory operation done
    input  wire logic        halt_entry,           // CPU enters halt
    input  wire logic        watchdog_active,      // Watchdog is running
    output logic             halt_reset_req,       // Reset on halt entry
    output logic             cfg_loaded,           // Settings captured
    output obc_clk_src_e     startup_clock_select, // Startup clock source
    output logic             wakeup_rc_oscillator, // Wakeup RC chosen
    output logic             external_clock_pin,   // External clock pin in use
    output logic      [1:0]  brownout_threshold_select, // Brownout threshold code
    output logic             brownout_enable,      // Brownout detector on
    output logic             watchdog_type_select, // Raw watchdog type bit
    output logic             watchdog_hw_enable,   // Watchdog forced on
    output logic             watchdog_halt_reset,  // Halt-reset option
    output logic      [11:0] sector_zero_size,     // Sector zero size in bytes
    output logic             readout_protect,      // Readout protection active
    output logic             program_write_protect,// Write protection active
    output logic             iap_write_allow,      // Software may write memory
    output logic             config_fault          // Fixed bits or clock code bad
);
    obc_cfg_if cfg_bus ();

    obc_hold u_hold (
        .clk    (clk),
        .rst_n  (rst_n),
        .clk_en (clk_en),
        .nv_su  (nv_startup_byte),
        .nv_pr  (nv_protect_byte),
        .loaded (cfg_loaded),
        .cfg    (cfg_bus.holder)
    );

    obc_decode u_decode (
        .cfg (cfg_bus.decoder)
    );

    // Decoded settings stay frozen until the next reset
    assign startup_clock_select      = cfg_bus.clk_src;  // [R1]
    assign wakeup_rc_oscillator      = (cfg_bus.clk_src == OBC_CLK_WAKEUP);  // [R1]
    assign external_clock_pin        = (cfg_bus.clk_src == OBC_CLK_EXT);  // [R1]
    assign brownout_threshold_select = cfg_bus.bod_sel;
    assign brownout_enable           = cfg_bus.bod_enable;
    assign watchdog_type_select      = !cfg_bus.wdt_hw_enable;
    assign watchdog_hw_enable        = cfg_bus.wdt_hw_enable;  // [R5]
    assign watchdog_halt_reset       = cfg_bus.wdt_halt_reset;
    assign sector_zero_size          = cfg_bus.sector_bytes;  // [R8]
    assign readout_protect           = cfg_bus.readout_protect;
    assign program_write_protect     = cfg_bus.program_write_protect;
    assign config_fault              = cfg_bus.fixed_bit_fault;

    // Software path writes only when neither protection is set
    assign iap_write_allow = !cfg_bus.readout_protect
                             && !cfg_bus.program_write_protect;  // [R9] [R11]

    // Halt reset request, registered so the reset unit sees a clean pulse
    logic next_halt_reset;

    always_comb
    begin
        next_halt_reset = halt_entry && watchdog_active
                          && cfg_bus.wdt_halt_reset;  // [R6]
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            halt_reset_req <= 1'b0;
        else if (clk_en)
            halt_reset_req <= next_halt_reset;
    end

    // Live protection bits guard programming at once, not after a reset,
    // so a freshly set lock cannot be bypassed in the same session
    logic live_rdp;
    logic live_wrp;

    assign live_rdp = nv_protect_byte[`OBC_PR_RDP];
    assign live_wrp = nv_protect_byte[`OBC_PR_WRP];

    // Programming sequencer state
    obc_state_e  state;
    obc_state_e  next_state;
    logic [7:0]  next_rdata;
    logic        next_done;
    logic        next_refused;
    logic        next_nv_write;
    logic        next_nv_wsel;
    logic [7:0]  next_nv_wdata;
    logic        next_mem_req;
    logic [1:0]  next_mem_op;
    logic [10:0] next_mem_addr;
    logic [7:0]  next_mem_wdata;
    logic        erase_second;
    logic        next_erase_second;
    logic        mem_read_op;
    logic        next_mem_read_op;

    // Command decode, protection checks and wait sequencing
    always_comb
    begin
        next_state        = state;
        next_rdata        = tool_rdata;
        next_done         = 1'b0;
        next_refused      = 1'b0;
        next_nv_write     = 1'b0;
        next_nv_wsel      = nv_wsel;
        next_nv_wdata     = nv_wdata;
        next_mem_req      = 1'b0;
        next_mem_op       = mem_op;
        next_mem_addr     = mem_addr;
        next_mem_wdata    = mem_wdata;
        next_erase_second = erase_second;
        next_mem_read_op  = mem_read_op;
        unique case (state)
            OBC_IDLE:
            begin
                if (tool_req)
                begin
                    if (!prog_mode)
                        next_refused = 1'b1;  // [R12]
                    else
                    begin
                        unique case (tool_cmd)
                            `OBC_CMD_RD_OPT:
                            begin
                                next_rdata = (tool_sel == `OBC_SEL_SU) ?
                                             nv_startup_byte : nv_protect_byte;  // [R12]
                                next_done  = 1'b1;
                            end
                            `OBC_CMD_WR_OPT:
                            begin
                                // Write protect locks the protection byte itself
                                if (live_wrp && tool_sel == `OBC_SEL_PR)
                                    next_refused = 1'b1;  // [R11]
                                else
                                begin
                                    next_nv_write = 1'b1;  // [R12]
                                    next_nv_wsel  = tool_sel;
                                    next_nv_wdata = tool_wdata;
                                    next_state    = OBC_NV_WAIT;
                                    next_erase_second = 1'b1;
                                end
                            end
                            `OBC_CMD_ER_OPT:
                            begin
                                if (live_wrp)
                                    next_refused = 1'b1;  // [R11]
                                else if (live_rdp)
                                begin
                                    // Wipe the whole memory before erasing both option bytes to FFh
                                    next_mem_req     = 1'b1;  // [R10]
                                    next_mem_op      = `OBC_MOP_ERASE;
                                    next_mem_addr    = 11'h000;
                                    next_mem_wdata   = `OBC_ERASED;  // [R13]
                                    next_state       = OBC_WIPE_WAIT;
                                end
                                else
                                    next_state = OBC_OPT_ERASE;
                                next_erase_second = 1'b0;
                            end
                            `OBC_CMD_RD_MEM:
                            begin
                                if (live_rdp)
                                    next_refused = 1'b1;  // [R9]
                                else
                                begin
                                    next_mem_req     = 1'b1;
                                    next_mem_op      = `OBC_MOP_READ;
                                    next_mem_addr    = tool_addr;
                                    next_mem_read_op = 1'b1;
                                    next_state       = OBC_MEM_WAIT;
                                end
                            end
                            `OBC_CMD_PR_MEM:
                            begin
                                if (live_rdp || live_wrp)
                                    next_refused = 1'b1;  // [R9] [R11]
                                else
                                begin
                                    next_mem_req     = 1'b1;
                                    next_mem_op      = `OBC_MOP_PROG;
                                    next_mem_addr    = tool_addr;
                                    next_mem_wdata   = tool_wdata;
                                    next_mem_read_op = 1'b0;
                                    next_state       = OBC_MEM_WAIT;
                                end
                            end
                            `OBC_CMD_ER_MEM:
                            begin
                                if (live_rdp || live_wrp)
                                    next_refused = 1'b1;  // [R9] [R11]
                                else
                                begin
                                    next_mem_req     = 1'b1;
                                    next_mem_op      = `OBC_MOP_ERASE;
                                    next_mem_addr    = 11'h000;
                                    next_mem_wdata   = `OBC_ERASED;  // [R13]
                                    next_mem_read_op = 1'b0;
                                    next_state       = OBC_MEM_WAIT;
                                end
                            end
                            default:
                                next_refused = 1'b1;  // Unused command codes
                        endcase
                    end
                end
            end
            OBC_NV_WAIT:
            begin
                // Option erase runs protection byte then startup byte
                if (nv_done && erase_second)
                begin
                    next_done  = 1'b1;
                    next_state = OBC_IDLE;
                end
                else if (nv_done)
                begin
                    next_state        = OBC_OPT_ERASE;
                    next_erase_second = 1'b1;
                end
            end
            OBC_MEM_WAIT:
            begin
                if (mem_done)
                begin
                    if (mem_read_op)
                        next_rdata = mem_rdata;
                    next_done  = 1'b1;
                    next_state = OBC_IDLE;
                end
            end
            OBC_WIPE_WAIT:
            begin
                if (mem_done)
                    next_state = OBC_OPT_ERASE;  // [R10]
            end
            OBC_OPT_ERASE:
            begin
                // Erased cells read FFh; startup byte goes second
                next_nv_write = 1'b1;
                next_nv_wsel  = erase_second ? `OBC_SEL_SU : `OBC_SEL_PR;
                next_nv_wdata = `OBC_ERASED;
                next_state    = OBC_NV_WAIT;
            end
        endcase
    end

    // Sequencer registers; everything holds while the enable is low
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state        <= OBC_IDLE;
            tool_rdata   <= 8'h00;
            tool_done    <= 1'b0;
            tool_refused <= 1'b0;
            nv_write     <= 1'b0;
            nv_wsel      <= 1'b0;
            nv_wdata     <= 8'h00;
            mem_req      <= 1'b0;
            mem_op       <= 2'h0;
            mem_addr     <= 11'h000;
            mem_wdata    <= 8'h00;
            erase_second <= 1'b0;
            mem_read_op  <= 1'b0;
        end
        else if (clk_en)
        begin
            state        <= next_state;
            tool_rdata   <= next_rdata;
            tool_done    <= next_done;
            tool_refused <= next_refused;
            nv_write     <= next_nv_write;
            nv_wsel      <= next_nv_wsel;
            nv_wdata     <= next_nv_wdata;
            mem_req      <= next_mem_req;
            mem_op       <= next_mem_op;
            mem_addr     <= next_mem_addr;
            mem_wdata    <= next_mem_wdata;
            erase_second <= next_erase_second;
            mem_read_op  <= next_mem_read_op;
        end
    end

    // Busy covers every state but idle
    assign tool_busy = (state != OBC_IDLE);
endmodule

// ===== verif/obc_chk_sva.sv
// Port assertions for the decoder
`timescale 1ns/100ps
module obc_chk
    import obc_pkg::*;
(
    input logic clk, rst_n, prog_mode, tool_req, tool_busy, tool_done, tool_refused, // Tool
    input logic halt_entry, watchdog_active, halt_reset_req, watchdog_halt_reset, // Halt
    input logic cfg_loaded, external_clock_pin, wakeup_rc_oscillator, brownout_enable, // Cfg
    input logic watchdog_type_select, watchdog_hw_enable, iap_write_allow, // Watchdog, IAP
    input logic readout_protect, program_write_protect, mem_req, // Protection, memory
    input logic [1:0] brownout_threshold_select, mem_op, // Codes
    input logic [11:0] sector_zero_size, // Sector size
    input obc_clk_src_e startup_clock_select // Clock source
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_halt; halt_entry && watchdog_active && watchdog_halt_reset |=> halt_reset_req;
    endproperty
    a_halt: assert property (p_halt) else $error("halt reset missing");
    property p_nohalt; !halt_entry |=> !halt_reset_req; endproperty
    a_nohalt: assert property (p_nohalt) else $error("halt reset unprompted");
    property p_clk; external_clock_pin == (startup_clock_select == OBC_CLK_EXT)
        && wakeup_rc_oscillator == (startup_clock_select == OBC_CLK_WAKEUP); endproperty
    a_clk: assert property (p_clk) else $error("clock pin flags wrong");
    property p_bod; brownout_enable == (brownout_threshold_select != 2'h3); endproperty
    a_bod: assert property (p_bod) else $error("brownout enable wrong");
    property p_wdt; watchdog_hw_enable != watchdog_type_select; endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog type wrong");
    property p_sec; sector_zero_size inside {12'h200, 12'h400, 12'h800}; endproperty
    a_sec: assert property (p_sec) else $error("sector size illegal");
    // Settings frozen after capture
    property p_hold; cfg_loaded |=> $stable(sector_zero_size) && $stable(readout_protect)
        && $stable(startup_clock_select); endproperty
    a_hold: assert property (p_hold) else $error("settings moved");
    property p_iap; iap_write_allow == (!readout_protect && !program_write_protect);
    endproperty
    a_iap: assert property (p_iap) else $error("write allow wrong");
    property p_ref; !prog_mode && tool_req && !tool_busy |=> tool_refused && !tool_done;
    endproperty
    a_ref: assert property (p_ref) else $error("access outside prog mode");
    c_ref: cover property (tool_refused);
    c_halt: cover property (halt_reset_req);
    c_wipe: cover property (mem_req && mem_op == 2'h2);
endmodule
bind obc_top obc_chk u_chk (.*);

// ===== verif/obc_nv_model.sv
// Option cells and program memory behind the decoder
`timescale 1ns/100ps
module obc_nv_model (
    input logic clk, nv_write, nv_wsel, mem_req, // Strobes
    input logic [7:0] nv_wdata, mem_wdata, // Write data
    input logic [1:0] mem_op, // Memory operation
    input logic [10:0] mem_addr, // Memory address
    output logic nv_done, mem_done, // Completions
    output logic [7:0] nv_startup_byte, nv_protect_byte, mem_rdata // Contents
);
    logic [7:0] mem [0:2047];
    logic [7:0] rd = 8'h00;
    int nv_cnt = 0, mem_cnt = 0;
    // Non-volatile: resets leave cells alone
    initial begin
        nv_startup_byte = 8'h2F; nv_protect_byte = 8'hF0; nv_done = 0; mem_done = 0;
        foreach (mem[i]) mem[i] = 8'hFF;
    end
    // Cells answer slowly, memory promptly
    always @(posedge clk) begin
        nv_done <= (nv_cnt == 1);
        mem_done <= (mem_cnt == 1);
        if (nv_cnt > 0) nv_cnt <= nv_cnt - 1;
        if (mem_cnt > 0) mem_cnt <= mem_cnt - 1;
        if (nv_write) begin
            nv_cnt <= 4;
            if (nv_wsel) nv_startup_byte <= nv_wdata; else nv_protect_byte <= nv_wdata;
        end
        if (mem_req) begin
            mem_cnt <= 2;
            if (mem_op == 2'h0) rd <= mem[mem_addr];
            if (mem_op == 2'h1) mem[mem_addr] <= mem_wdata;
            if (mem_op == 2'h2) foreach (mem[i]) mem[i] <= 8'hFF;
        end
    end
    // Idle bus shows the inverse
    assign mem_rdata = mem_done ? rd : ~rd;
endmodule

// ===== verif/testbench.sv
// Self-checking bench for the option byte decoder
`timescale 1ns/100ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin num_errors++; \
    $display("MISMATCH %s exp %h got %h", n, e, a); end end
module testbench;
    import obc_pkg::*;
    logic clk = 0, rst_n = 0, clk_en = 1, prog_mode = 1, tool_req = 0, tool_sel = 0;
    logic halt_entry = 0, watchdog_active = 0, ok, refused;
    logic [2:0] tool_cmd = 0;
    logic [10:0] tool_addr = 11'h005, mem_addr;
    logic [7:0] tool_wdata = 0, tool_rdata, rd, nv_startup_byte, nv_protect_byte;
    logic [7:0] nv_wdata, mem_wdata, mem_rdata;
    logic tool_done, tool_refused, tool_busy, nv_write, nv_wsel, nv_done, mem_req, mem_done;
    logic halt_reset_req, cfg_loaded, wakeup_rc_oscillator, external_clock_pin;
    logic brownout_enable, watchdog_type_select, watchdog_hw_enable, watchdog_halt_reset;
    logic readout_protect, program_write_protect, iap_write_allow, config_fault;
    logic [1:0] mem_op, brownout_threshold_select;
    logic [11:0] sector_zero_size;
    obc_clk_src_e startup_clock_select;
    int num_errors = 0, total_checks = 0, cyc = 0;
    obc_top u_dut (.*);
    obc_nv_model u_nv (.*);
    always #10 clk = ~clk;
    // One request, bounded wait
    task automatic op(input logic [2:0] c, input logic s, input logic [7:0] d);
        tool_cmd = c; tool_sel = s; tool_wdata = d; tool_req = 1;
        @(posedge clk); #1 tool_req = 0;
        repeat (200) if (!(tool_done || tool_refused)) begin @(posedge clk); #1; end
        ok = tool_done; refused = tool_refused; rd = tool_rdata;
    endtask
    task rs;
        rst_n = 0; repeat (6) @(posedge clk); #1 rst_n = 1; @(posedge clk); #1;
    endtask
    task t_dflt;
        rs; `CHK("loaded", 1'b1, cfg_loaded)
        `CHK("clk", OBC_CLK_RC, startup_clock_select)
        `CHK("bod", 1'b0, brownout_enable)
        `CHK("wdt", 1'b0, watchdog_hw_enable)
        `CHK("sec", 12'h200, sector_zero_size)
        halt_entry = 1; watchdog_active = 1; @(posedge clk); #1;
        `CHK("halt", 1'b1, halt_reset_req)
        halt_entry = 0; $display("t_dflt done");
    endtask
    task t_cfg;
        op(3'h1, 1'b1, 8'hE0); op(3'h1, 1'b0, 8'hF8);
        `CHK("hold", OBC_CLK_RC, startup_clock_select)
        op(3'h0, 1'b1, 8'h00); `CHK("rd", 8'hE0, rd)
        rs; `CHK("ext", 1'b1, external_clock_pin)
        `CHK("bodsel", 2'h0, brownout_threshold_select)
        `CHK("hw", 1'b1, watchdog_hw_enable)
        `CHK("sec1k", 12'h400, sector_zero_size)
        halt_entry = 1; @(posedge clk); #1; `CHK("nohalt", 1'b0, halt_reset_req)
        halt_entry = 0; $display("t_cfg done");
    endtask
    task t_ref;
        prog_mode = 0; op(3'h0, 1'b1, 8'h00); `CHK("ref", 1'b1, refused)
        prog_mode = 1; op(3'h7, 1'b0, 8'h00); `CHK("bad", 1'b1, refused)
        $display("t_ref done");
    endtask
    task t_prot;
        op(3'h4, 1'b0, 8'h3C); op(3'h3, 1'b0, 8'h00); `CHK("mem", 8'h3C, rd)
        op(3'h1, 1'b0, 8'hF6); op(3'h3, 1'b0, 8'h00); `CHK("rdblk", 1'b1, refused)
        op(3'h4, 1'b0, 8'h11); `CHK("wrblk", 1'b1, refused)
        op(3'h2, 1'b0, 8'h00); `CHK("erase", 1'b1, ok)
        `CHK("wipe", 8'hFF, u_nv.mem[5])
        rs; `CHK("sec2k", 12'h800, sector_zero_size)
        `CHK("wrp", 1'b1, program_write_protect)
        op(3'h1, 1'b0, 8'hF0); `CHK("wrpbit", 1'b1, refused)
        op(3'h2, 1'b0, 8'h00); `CHK("wrper", 1'b1, refused)
        $display("t_prot done");
    endtask
    initial begin
        t_dflt; t_cfg; t_ref; t_prot;
        conclude;
    end
    // Run ceiling
    always @(posedge clk) begin
        cyc++;
        if (cyc > 5000) begin num_errors++; conclude; end
    end
    task conclude;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
endmodule
